// *** pkg/atc_params.svh ***
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timebase figures
// ----------------------------------------------------------------
`define ATC_CLK_HZ          20000000
`define ATC_TB_HZ           1000000
// System cycles in one half period of the 1 MHz timebase.
`define ATC_TB_HALF_CYC     ((`ATC_CLK_HZ / `ATC_TB_HZ) / 2)
`define ATC_TB_CNT_W        4

// ----------------------------------------------------------------
// Conversion deadline
// ----------------------------------------------------------------
`define ATC_CONV_LIMIT_NS   20000
// A longest time, so the division rounds down.
`define ATC_CONV_LIMIT_CYC  ((`ATC_CONV_LIMIT_NS * (`ATC_CLK_HZ / 1000000)) / 1000)
`define ATC_CONV_CNT_W      9

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define ATC_CNT_W           16
`define ATC_DATA_W          16
`define ATC_CNT_RST         16'hFFFF
`define ATC_NUM_GP          2

`endif

// *** pkg/atc_pkg.sv ***
`default_nettype none

package atc_pkg;

	// Conversion sequencer states.
	typedef enum logic [1:0] {
		ATC_CONV_IDLE,
		ATC_CONV_BUSY
	} atc_conv_state_type;

	// Gating style of a general-purpose counter.
	typedef enum logic {
		ATC_GATE_LEVEL,
		ATC_GATE_EDGE
	} atc_gate_mode_type;

endpackage

`default_nettype wire

// *** pkg/atc_cnt_if.sv ***
`default_nettype none

`include "atc_params.svh"

// Control and status of one general-purpose counter.
interface atc_cnt_if;
	logic                      clk_level;
	logic                      gate_level;
	logic                      count_fall;
	atc_pkg::atc_gate_mode_type gate_mode;
	logic                      load;
	logic [`ATC_CNT_W-1:0]     load_value;
	logic [`ATC_CNT_W-1:0]     count;
	logic                      out;

	modport ctrl (
		output clk_level, gate_level, count_fall, gate_mode, load, load_value,
		input  count, out
	);
	modport cnt (
		input  clk_level, gate_level, count_fall, gate_mode, load, load_value,
		output count, out
	);
endinterface

`default_nettype wire

// *** rtl/atc_gp_counter.sv ***
`default_nettype none

`include "atc_params.svh"

module atc_gp_counter (
	input  wire logic  clk_sys_in,
	input  wire logic  rst_in,
	atc_cnt_if.cnt     cif
);

	// ----------------------------------------------------------------
	// Edge detection of the synchronised counter clock
	// ----------------------------------------------------------------
	logic                  clk_prev_reg;
	logic                  gate_smp_reg;
	logic                  armed_reg;
	logic [`ATC_CNT_W-1:0] count_reg;
	logic                  out_reg;

	wire logic rise     = cif.clk_level & ~clk_prev_reg;
	wire logic fall     = ~cif.clk_level & clk_prev_reg;
	wire logic cnt_edge = cif.count_fall ? fall : rise;
	// Gate edge seen at a counter clock rising edge.
	wire logic gate_up  = rise & cif.gate_level & ~gate_smp_reg;
	wire logic run      = (cif.gate_mode == atc_pkg::ATC_GATE_EDGE) ? armed_reg : gate_smp_reg;

	// Previous clock level, used only for edge detection. It resets high like the
	// synchroniser, so leaving reset does not look like a rising clock edge.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			clk_prev_reg <= 1'b1;
		end else begin
			clk_prev_reg <= cif.clk_level;
		end
	end

	// gate sampled on rise
	// Resets to the pulled-up idle level, so no false gate edge arms the counter.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			gate_smp_reg <= 1'b1;
		end else if (rise) begin
			gate_smp_reg <= cif.gate_level;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || cif.load) begin
			armed_reg <= 1'b0;
		end else if (gate_up) begin
			armed_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			count_reg <= `ATC_CNT_RST;
		end else if (cif.load) begin
			count_reg <= cif.load_value;
		end else if (cnt_edge && run) begin
			count_reg <= count_reg - `ATC_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			out_reg <= 1'b0;
		end else if (rise) begin
			out_reg <= (count_reg == '0);
		end
	end

	assign cif.count = count_reg;
	assign cif.out   = out_reg;

endmodule

`default_nettype wire

// *** rtl/atc_timing.sv ***
`default_nettype none

`include "atc_params.svh"

module atc_timing (
	input  wire logic                   clk_sys_in,
	input  wire logic                   rst_in,
	input  wire logic                   acq_enable_in,
	input  wire logic                   ext_trig_select_in,
	input  wire logic [`ATC_CNT_W-1:0]  sample_interval_load_in,
	input  wire logic                   ext_convert_trigger_n_in,
	input  wire logic                   adc_done_in,
	input  wire logic [`ATC_DATA_W-1:0] adc_data_in,
	output logic                        conv_start_out,
	output logic                        fifo_write_out,
	output logic [`ATC_DATA_W-1:0]      fifo_data_out,
	output logic                        conv_timeout_out,
	output logic                        timebase_1mhz_out,
	input  wire logic                   counter1_clock_in,
	output logic                        counter1_out,
	input  wire logic                   cnt1_count_fall_in,
	input  wire logic                   cnt1_load_in,
	input  wire logic [`ATC_CNT_W-1:0]  cnt1_load_value_in,
	output logic [`ATC_CNT_W-1:0]       cnt1_count_out,
	input  wire logic                   counter2_gate_in,
	input  wire logic                   counter2_clock_in,
	output logic                        counter2_out,
	input  wire logic                   cnt2_count_fall_in,
	input  wire logic                   cnt2_edge_gated_in,
	input  wire logic                   cnt2_load_in,
	input  wire logic [`ATC_CNT_W-1:0]  cnt2_load_value_in,
	output logic [`ATC_CNT_W-1:0]       cnt2_count_out
);

	// ----------------------------------------------------------------
	// 1 MHz timebase
	// ----------------------------------------------------------------
	logic [`ATC_TB_CNT_W-1:0] tb_cnt_reg;
	logic                     tb_wave_reg;

	wire logic tb_half = (tb_cnt_reg == `ATC_TB_CNT_W'(`ATC_TB_HALF_CYC - 1));
	// One-cycle enable at each rising edge of the square wave.
	wire logic tb_tick = tb_half & ~tb_wave_reg;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tb_cnt_reg  <= '0;
			tb_wave_reg <= 1'b0;
		end else if (tb_half) begin
			tb_cnt_reg  <= '0;
			tb_wave_reg <= ~tb_wave_reg;
		end else begin
			tb_cnt_reg  <= tb_cnt_reg + `ATC_TB_CNT_W'(1);
		end
	end

	assign timebase_1mhz_out = tb_wave_reg;

	// ----------------------------------------------------------------
	// Sample-interval counter (counter 0)
	// ----------------------------------------------------------------
	logic [`ATC_CNT_W-1:0] si_cnt_reg;
	logic                  si_out_reg;
	logic                  si_prev_reg;

	wire logic si_zero = (si_cnt_reg <= `ATC_CNT_W'(1));

	// pulse and reload
	// Output dips low for one microsecond at terminal count; its
	// return high is the edge that paces a conversion.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !acq_enable_in) begin
			si_cnt_reg <= sample_interval_load_in;
			si_out_reg <= 1'b1;
		end else if (tb_tick) begin
			si_cnt_reg <= si_zero ? sample_interval_load_in : si_cnt_reg - `ATC_CNT_W'(1);
			si_out_reg <= ~si_zero;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			si_prev_reg <= 1'b1;
		end else begin
			si_prev_reg <= si_out_reg;
		end
	end

	wire logic sample_interval_out = si_out_reg;
	wire logic si_rise = sample_interval_out & ~si_prev_reg & acq_enable_in;

	// ----------------------------------------------------------------
	// External trigger synchroniser
	// ----------------------------------------------------------------
	// pin is input only
	logic ext_s1_reg;
	logic ext_s2_reg;
	logic ext_prev_reg;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ext_s1_reg   <= 1'b1;
			ext_s2_reg   <= 1'b1;
			ext_prev_reg <= 1'b1;
		end else begin
			ext_s1_reg   <= ext_convert_trigger_n_in;
			ext_s2_reg   <= ext_s1_reg;
			ext_prev_reg <= ext_s2_reg;
		end
	end

	wire logic ext_rise = ext_s2_reg & ~ext_prev_reg;

	wire logic conv_req = ext_trig_select_in ? (ext_rise & acq_enable_in) : si_rise;

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	atc_pkg::atc_conv_state_type conv_state_reg;
	logic [`ATC_CONV_CNT_W-1:0]  conv_cnt_reg;
	logic                        start_reg;
	logic                        wr_reg;
	logic                        tmo_reg;
	logic [`ATC_DATA_W-1:0]      data_reg;

	wire logic idle = (conv_state_reg == atc_pkg::ATC_CONV_IDLE);
	wire logic conv_late = (conv_cnt_reg == `ATC_CONV_CNT_W'(`ATC_CONV_LIMIT_CYC - 1));
	wire logic conv_end  = !idle && (adc_done_in || conv_late);

	// ignore while busy
	// A late converter still yields a FIFO entry, holding the last
	// data word, so software sample counts stay in step.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			conv_state_reg <= atc_pkg::ATC_CONV_IDLE;
			conv_cnt_reg   <= '0;
		end else begin
			case (conv_state_reg)
				atc_pkg::ATC_CONV_IDLE: begin
					conv_cnt_reg <= '0;
					if (conv_req) begin
						conv_state_reg <= atc_pkg::ATC_CONV_BUSY;
					end
				end
				atc_pkg::ATC_CONV_BUSY: begin
					conv_cnt_reg <= conv_cnt_reg + `ATC_CONV_CNT_W'(1);
					if (conv_end) begin
						conv_state_reg <= atc_pkg::ATC_CONV_IDLE;
					end
				end
				default: begin
					conv_state_reg <= atc_pkg::ATC_CONV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			start_reg <= 1'b0;
			wr_reg    <= 1'b0;
			tmo_reg   <= 1'b0;
			data_reg  <= '0;
		end else begin
			start_reg <= idle & conv_req;
			wr_reg    <= conv_end;
			tmo_reg   <= conv_end & ~adc_done_in;
			if (conv_end && adc_done_in) begin
				data_reg <= adc_data_in;
			end
		end
	end

	assign conv_start_out   = start_reg;
	assign fifo_write_out   = wr_reg;
	assign conv_timeout_out = tmo_reg;
	assign fifo_data_out    = data_reg;

	// ----------------------------------------------------------------
	// General-purpose counters 1 and 2
	// ----------------------------------------------------------------
	atc_cnt_if cif [`ATC_NUM_GP] ();

	wire logic [`ATC_NUM_GP-1:0] pin_clk  = {counter2_clock_in, counter1_clock_in};
	wire logic [`ATC_NUM_GP-1:0] pin_gate = {counter2_gate_in, 1'b1};
	wire logic [`ATC_NUM_GP-1:0] cfg_fall = {cnt2_count_fall_in, cnt1_count_fall_in};
	wire logic [`ATC_NUM_GP-1:0] cfg_edge = {cnt2_edge_gated_in, 1'b0};
	wire logic [`ATC_NUM_GP-1:0] cfg_load = {cnt2_load_in, cnt1_load_in};
	wire logic [`ATC_CNT_W-1:0]  cfg_val [`ATC_NUM_GP];
	wire logic [`ATC_CNT_W-1:0]  cnt_val [`ATC_NUM_GP];
	wire logic [`ATC_NUM_GP-1:0] cnt_out;

	assign cfg_val[0] = cnt1_load_value_in;
	assign cfg_val[1] = cnt2_load_value_in;

	genvar gi;
	generate
		for (gi = 0; gi < `ATC_NUM_GP; gi++) begin : g_gp
			logic clk_s1_reg;
			logic clk_s2_reg;
			logic gate_s1_reg;
			logic gate_s2_reg;

			// Pin inputs pass two flip-flops before any logic sees them.
			always_ff @(posedge clk_sys_in) begin
				if (rst_in) begin
					clk_s1_reg  <= 1'b1;
					clk_s2_reg  <= 1'b1;
					gate_s1_reg <= 1'b1;
					gate_s2_reg <= 1'b1;
				end else begin
					clk_s1_reg  <= pin_clk[gi];
					clk_s2_reg  <= clk_s1_reg;
					gate_s1_reg <= pin_gate[gi];
					gate_s2_reg <= gate_s1_reg;
				end
			end

			assign cif[gi].clk_level  = clk_s2_reg;
			assign cif[gi].gate_level = gate_s2_reg;
			assign cif[gi].count_fall = cfg_fall[gi];
			assign cif[gi].gate_mode  = cfg_edge[gi] ? atc_pkg::ATC_GATE_EDGE
			                                         : atc_pkg::ATC_GATE_LEVEL;
			assign cif[gi].load       = cfg_load[gi];
			assign cif[gi].load_value = cfg_val[gi];
			assign cnt_val[gi]        = cif[gi].count;
			assign cnt_out[gi]        = cif[gi].out;

			atc_gp_counter u_cnt (
				.clk_sys_in (clk_sys_in),
				.rst_in     (rst_in),
				.cif        (cif[gi])
			);
		end
	endgenerate

	assign cnt1_count_out = cnt_val[0];
	assign cnt2_count_out = cnt_val[1];
	assign counter1_out   = cnt_out[0];
	assign counter2_out   = cnt_out[1];

endmodule

`default_nettype wire

// *** tb/atc_timing_sva.sv ***
`default_nettype none

`include "atc_params.svh"

module atc_timing_sva (
	input wire logic                   clk_sys_in,
	input wire logic                   rst_in,
	input wire logic                   acq_enable_in,
	input wire logic                   ext_trig_select_in,
	input wire logic                   ext_convert_trigger_n_in,
	input wire logic                   adc_done_in,
	input wire logic [`ATC_DATA_W-1:0] adc_data_in,
	input wire logic                   conv_start_out,
	input wire logic                   fifo_write_out,
	input wire logic [`ATC_DATA_W-1:0] fifo_data_out,
	input wire logic                   conv_timeout_out,
	input wire logic                   timebase_1mhz_out,
	input wire logic                   cnt1_load_in,
	input wire logic [`ATC_CNT_W-1:0]  cnt1_load_value_in,
	input wire logic [`ATC_CNT_W-1:0]  cnt1_count_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic busy_reg;

	// Shadow of the sequencer, so a start can be judged against the one before it.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || fifo_write_out) begin
			busy_reg <= 1'b0;
		end else if (conv_start_out) begin
			busy_reg <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	chk_start_once: assert property (conv_start_out |=> !conv_start_out)
		else $error("conversion start longer than one cycle");
	chk_start_idle: assert property (conv_start_out |-> !busy_reg)
		else $error("conversion started while busy");
	chk_write_bound: assert property (conv_start_out |-> ##[1:401] fifo_write_out)
		else $error("no sample write within the deadline");
	chk_write_cause: assert property (fifo_write_out |-> $past(adc_done_in) || conv_timeout_out)
		else $error("sample write without a cause");
	chk_data_latch: assert property (fifo_write_out && !conv_timeout_out |->
		fifo_data_out == $past(adc_data_in))
		else $error("sample data differs from converter result");
	chk_ext_start: assert property ($rose(ext_convert_trigger_n_in) && ext_trig_select_in &&
		acq_enable_in && !busy_reg |-> ##3 conv_start_out)
		else $error("trigger edge did not start a conversion");
	chk_tb_high: assert property ($rose(timebase_1mhz_out) |->
		timebase_1mhz_out[*8] ##1 timebase_1mhz_out[*2] ##1 !timebase_1mhz_out)
		else $error("timebase high phase wrong");
	chk_tb_low: assert property ($fell(timebase_1mhz_out) |->
		(!timebase_1mhz_out)[*8] ##1 (!timebase_1mhz_out)[*2] ##1 timebase_1mhz_out)
		else $error("timebase low phase wrong");
	chk_cnt_load: assert property (cnt1_load_in |=> cnt1_count_out == $past(cnt1_load_value_in))
		else $error("counter load value not taken");
endmodule

bind atc_timing atc_timing_sva i_atc_timing_sva (.clk_sys_in, .rst_in, .acq_enable_in,
	.ext_trig_select_in, .ext_convert_trigger_n_in, .adc_done_in, .adc_data_in, .conv_start_out,
	.fifo_write_out, .fifo_data_out, .conv_timeout_out, .timebase_1mhz_out, .cnt1_load_in,
	.cnt1_load_value_in, .cnt1_count_out);

`default_nettype wire

// *** tb/atc_adc_model.sv ***
`default_nettype none

`include "atc_params.svh"

module atc_adc_model (
	input  wire logic                   clk_sys_in,
	input  wire logic                   rst_in,
	input  wire logic                   conv_start_in,
	input  wire logic [8:0]             delay_in,
	input  wire logic [`ATC_DATA_W-1:0] value_in,
	output logic                        adc_done_out,
	output logic [`ATC_DATA_W-1:0]      adc_data_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [8:0] wait_reg;

	// A delay of zero is a converter that never answers; outside done the data churns.
	always_ff @(posedge clk_sys_in) begin
		adc_done_out <= 1'b0;
		adc_data_out <= adc_data_out ^ 16'h5A5A;
		if (rst_in) begin
			wait_reg <= 9'h000;
			adc_data_out <= 16'h0000;
		end else if (conv_start_in) begin
			wait_reg <= delay_in;
		end else if (wait_reg != 9'h000) begin
			wait_reg <= wait_reg - 9'h001;
			if (wait_reg == 9'h001) begin
				adc_done_out <= 1'b1;
				adc_data_out <= value_in;
			end
		end
	end
endmodule

`default_nettype wire

// *** tb/atc_timing_test.sv ***
`default_nettype none

`include "atc_params.svh"

module atc_timing_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys_in, rst_in, acq_en, ext_sel, trig_n, adc_done, conv_start, fifo_write;
	logic        timeout, tbase, c1_clk, c1_fall, c1_ld, c1_out, c2_gate, c2_clk, c2_out;
	logic        c2_fall, c2_edge, c2_ld, last_to;
	logic [15:0] sil, adc_data, adc_value, fifo_data, last_data, c1_val, c1_cnt, c2_val, c2_cnt;
	logic [8:0]  adc_delay;
	int          err_total, samples_checked, n_start, n_write, n_tb;

	atc_timing i_atc_timing (.clk_sys_in, .rst_in, .acq_enable_in(acq_en),
		.ext_trig_select_in(ext_sel), .sample_interval_load_in(sil),
		.ext_convert_trigger_n_in(trig_n), .adc_done_in(adc_done), .adc_data_in(adc_data),
		.conv_start_out(conv_start), .fifo_write_out(fifo_write), .fifo_data_out(fifo_data),
		.conv_timeout_out(timeout), .timebase_1mhz_out(tbase), .counter1_clock_in(c1_clk),
		.counter1_out(c1_out), .cnt1_count_fall_in(c1_fall), .cnt1_load_in(c1_ld),
		.cnt1_load_value_in(c1_val), .cnt1_count_out(c1_cnt), .counter2_gate_in(c2_gate),
		.counter2_clock_in(c2_clk), .counter2_out(c2_out), .cnt2_count_fall_in(c2_fall),
		.cnt2_edge_gated_in(c2_edge), .cnt2_load_in(c2_ld), .cnt2_load_value_in(c2_val),
		.cnt2_count_out(c2_cnt));

	atc_adc_model i_atc_adc_model (.clk_sys_in, .rst_in, .conv_start_in(conv_start),
		.delay_in(adc_delay), .value_in(adc_value), .adc_done_out(adc_done),
		.adc_data_out(adc_data));

	// Clock at 20 MHz.
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	// Outputs are tallied on the falling edge, where they have settled.
	always @(negedge clk_sys_in) begin
		if (conv_start === 1'b1) n_start++;
		if (tbase === 1'b1) n_tb++;
		if (fifo_write === 1'b1) begin
			n_write++;
			last_data = fifo_data;
			last_to = timeout;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	task automatic edge_pin();
		trig_n <= 1'b0;
		tick(4);
		trig_n <= 1'b1;
	endtask

	// Pin levels are held four cycles each so the synchronisers never miss one.
	task automatic pulses(input logic two, input int n);
		repeat (n) begin
			c1_clk <= !two;
			c2_clk <= two;
			tick(4);
			c1_clk <= 1'b0;
			c2_clk <= 1'b0;
			tick(4);
		end
		tick(6);
	endtask

	task automatic load_cnt(input logic two, input logic [15:0] v);
		c1_val <= v;
		c2_val <= v;
		c1_ld <= !two;
		c2_ld <= two;
		tick(1);
		c1_ld <= 1'b0;
		c2_ld <= 1'b0;
		tick(2);
	endtask

	// external trigger path; a second edge while busy must be dropped.
	task automatic t_ext();
		ext_sel <= 1'b1;
		acq_en <= 1'b1;
		adc_delay <= 9'h01E;
		adc_value <= 16'h1234;
		n_start = 0;
		n_write = 0;
		edge_pin();
		tick(8);
		chk("ext start", 16'h0001, 16'(n_start));
		edge_pin();
		tick(40);
		chk("busy edge", 16'h0001, 16'(n_start));
		chk("write", 16'h0001, 16'(n_write));
		chk("data", 16'h1234, last_data);
		chk("no timeout", 16'h0000, 16'(last_to));
	endtask

	// silent converter still yields a write within the deadline.
	task automatic t_timeout();
		adc_delay <= 9'h000;
		n_write = 0;
		edge_pin();
		tick(420);
		chk("timeout write", 16'h0001, 16'(n_write));
		chk("timeout flag", 16'h0001, 16'(last_to));
	endtask

	// paced conversions every 2 us, trigger pin ignored meanwhile.
	task automatic t_paced();
		ext_sel <= 1'b0;
		acq_en <= 1'b0;
		sil <= 16'h0002;
		adc_delay <= 9'h005;
		tick(4);
		n_start = 0;
		acq_en <= 1'b1;
		for (int i = 0; i < 100 && n_start == 0; i++) tick(1);
		chk("first pace", 16'h0001, 16'(n_start));
		n_start = 0;
		n_tb = 0;
		tick(200);
		edge_pin();
		tick(216);
		chk("pace count", 16'h000A, 16'(n_start));
		chk("timebase high", 16'h00D2, 16'(n_tb));
		acq_en <= 1'b0;
		tick(4);
		n_start = 0;
		tick(100);
		chk("acq off", 16'h0000, 16'(n_start));
	endtask

	// counter 1 edge selection with its gate fixed on.
	task automatic t_cnt1();
		c1_fall <= 1'b0;
		pulses(1'b0, 1);
		load_cnt(1'b0, 16'h0064);
		chk("cnt1 load", 16'h0064, c1_cnt);
		pulses(1'b0, 5);
		chk("cnt1 rise", 16'h005F, c1_cnt);
		c1_fall <= 1'b1;
		c1_clk <= 1'b1;
		tick(8);
		chk("cnt1 rise held", 16'h005F, c1_cnt);
		c1_clk <= 1'b0;
		tick(8);
		chk("cnt1 fall", 16'h005E, c1_cnt);
	endtask

	// level gate pauses and resumes falling edge counts.
	task automatic t_cnt2_level();
		c2_edge <= 1'b0;
		c2_fall <= 1'b1;
		c2_gate <= 1'b1;
		tick(4);
		pulses(1'b1, 1);
		load_cnt(1'b1, 16'h0010);
		pulses(1'b1, 4);
		chk("cnt2 gated on", 16'h000C, c2_cnt);
		c2_gate <= 1'b0;
		tick(4);
		pulses(1'b1, 4);
		chk("cnt2 paused", 16'h000C, c2_cnt);
		c2_gate <= 1'b1;
		tick(4);
		pulses(1'b1, 2);
		chk("cnt2 resumed", 16'h000A, c2_cnt);
	endtask

	// edge gate starts counting and keeps it going.
	task automatic t_cnt2_edge();
		c2_edge <= 1'b1;
		c2_gate <= 1'b0;
		tick(4);
		load_cnt(1'b1, 16'h0010);
		pulses(1'b1, 3);
		chk("cnt2 unarmed", 16'h0010, c2_cnt);
		c2_gate <= 1'b1;
		tick(4);
		pulses(1'b1, 1);
		c2_gate <= 1'b0;
		tick(4);
		pulses(1'b1, 3);
		chk("cnt2 armed", 16'h000C, c2_cnt);
	endtask

	// counter 1 output gives counter 2 a known gate window.
	task automatic t_freq();
		c1_fall <= 1'b0;
		c2_edge <= 1'b0;
		load_cnt(1'b0, 16'h0001);
		pulses(1'b0, 1);
		chk("cnt1 out low", 16'h0000, 16'(c1_out));
		pulses(1'b0, 1);
		chk("cnt1 out high", 16'h0001, 16'(c1_out));
		c2_gate <= c1_out;
		load_cnt(1'b1, 16'h0010);
		pulses(1'b1, 3);
		pulses(1'b0, 1);
		c2_gate <= c1_out;
		tick(4);
		pulses(1'b1, 3);
		chk("freq window", 16'h000D, c2_cnt);
		c2_gate <= 1'b1;
		load_cnt(1'b1, 16'h0001);
		pulses(1'b1, 1);
		chk("cnt2 out low", 16'h0000, 16'(c2_out));
		pulses(1'b1, 1);
		chk("cnt2 out high", 16'h0001, 16'(c2_out));
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence after a 16 cycle reset.
	initial begin
		{rst_in, acq_en, ext_sel, trig_n, c1_clk, c1_fall, c1_ld} = 7'h40;
		{c2_gate, c2_clk, c2_fall, c2_edge, c2_ld} = 5'h00;
		{sil, adc_value, c1_val, c2_val, adc_delay} = '0;
		tick(16);
		rst_in <= 1'b0;
		tick(3);
		t_ext();
		t_timeout();
		t_paced();
		t_cnt1();
		t_cnt2_level();
		t_cnt2_edge();
		t_freq();
		give_verdict();
	end

	// The run needs about 1500 cycles, so 4000 means a hang.
	initial begin
		#(4000 * 50);
		err_total++;
		give_verdict();
	end
endmodule

`default_nettype wire
